/* core/axlr_pkg.sv */
// shared constants, types and helpers for the register access block
package axlr_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int AXLR_ADDR_W = 32;
	localparam int AXLR_DATA_W = 32;
	localparam int AXLR_STRB_W = 4;
	localparam int AXLR_CNT_W = 48;

	// ****************************************
	// response codes
	// ****************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_EXOKAY = 2'h1;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ****************************************
	// device pages and offsets
	// ****************************************
	localparam logic [31:0] CFG_PAGE_BASE = 32'h0000_0000;
	localparam logic [31:0] STAT_PAGE_BASE = 32'h0000_0200;
	localparam logic [31:0] PAGE_BYTES = 32'h0000_0200;
	localparam logic [31:0] OFF_VERSION = 32'h0000_0000;
	localparam logic [31:0] OFF_XCVR_RST = 32'h0000_0004;
	localparam logic [31:0] OFF_PATH_RST = 32'h0000_0008;
	localparam logic [31:0] OFF_TX_CFG = 32'h0000_000c;
	localparam logic [31:0] OFF_TX_DIAG = 32'h0000_0010;
	localparam logic [31:0] OFF_RX_CFG = 32'h0000_0014;
	localparam logic [31:0] OFF_LOOPBACK = 32'h0000_0018;
	localparam logic [31:0] OFF_CFG_GAP = 32'h0000_001c;
	localparam logic [31:0] OFF_STATUS = 32'h0000_0200;
	localparam logic [31:0] OFF_TICK = 32'h0000_02b0;
	localparam logic [31:0] OFF_CYC_LSB = 32'h0000_02b8;
	localparam logic [31:0] OFF_CYC_MSB = 32'h0000_02bc;
	localparam logic [31:0] OFF_ERR_LSB = 32'h0000_02c0;
	localparam logic [31:0] OFF_ERR_MSB = 32'h0000_02c4;
	localparam int XCVR_RST_BIT = 0;
	localparam int CNT_MSB_SHIFT = 32;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

	// ****************************************
	// controller offsets and fields
	// ****************************************
	localparam logic [31:0] H_OFF_CTRL = 32'h0000_0000;
	localparam logic [31:0] H_OFF_ADDR = 32'h0000_0004;
	localparam logic [31:0] H_OFF_WDATA = 32'h0000_0008;
	localparam logic [31:0] H_OFF_STRB = 32'h0000_000c;
	localparam logic [31:0] H_OFF_RDATA = 32'h0000_0010;
	localparam logic [31:0] H_OFF_STATUS = 32'h0000_0014;
	localparam logic [31:0] H_OFF_TICK = 32'h0000_0018;
	localparam int CTRL_WR_BIT = 0;
	localparam int CTRL_RD_BIT = 1;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_WERR_BIT = 2;
	localparam int ST_RERR_BIT = 3;
	localparam logic [3:0] STRB_RESET = 4'hf;
	localparam logic [1:0] BUS_RST_CYCLES = 2'h2;

	// ****************************************
	// access state machine
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WRITE = 2'b01,
		ST_READ = 2'b10,
		ST_ACK = 2'b11
	} axlr_state_e;

	// merge write data into a word by byte lanes
	function automatic logic [31:0] apply_strb(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return res;
	endfunction

	// error response test
	function automatic logic is_err(input logic [1:0] resp);
		return (resp == RESP_SLVERR) || (resp == RESP_DECERR);
	endfunction

endpackage

/* core/axlr_if.sv */
// axi4-lite link between controller and register map
`timescale 1ns/1ps
interface axlr_if;
	import axlr_pkg::*;
	logic [AXLR_ADDR_W-1:0] awaddr;
	logic awvalid;
	logic awready;
	logic [AXLR_DATA_W-1:0] wdata;
	logic [AXLR_STRB_W-1:0] wstrb;
	logic wvalid;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready;
	logic [AXLR_ADDR_W-1:0] araddr;
	logic arvalid;
	logic arready;
	logic [AXLR_DATA_W-1:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready;
	logic bus_sync_reset;
	logic perf_snapshot_pulse;

	modport dev (
		input awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
		input bus_sync_reset, perf_snapshot_pulse,
		output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
	);
	modport host (
		output awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
		output bus_sync_reset, perf_snapshot_pulse,
		input awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
	);
endinterface

/* core/axlr_stat_cnt.sv */
// saturating event accumulator with snapshot register
`timescale 1ns/1ps
module axlr_stat_cnt
	import axlr_pkg::*;
#(
	parameter int W = AXLR_CNT_W
)(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_srst,
	input wire logic i_inc,
	input wire logic i_snap,
	output logic [W-1:0] o_count
);
	logic [W-1:0] acc_r;
	logic [W-1:0] snap_r;

	// accumulate, saturate to ones, restart on snapshot
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			acc_r <= '0;
		else if (i_srst)
			acc_r <= '0;
		else if (i_snap)
			acc_r <= {{(W-1){1'b0}}, i_inc};
		else if (i_inc && (acc_r != {W{1'b1}}))
			acc_r <= acc_r + {{(W-1){1'b0}}, 1'b1};
	end

	// readable copy, held until the next snapshot
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			snap_r <= '0;
		else if (i_srst)
			snap_r <= '0;
		else if (i_snap)
			snap_r <= acc_r;
	end

	assign o_count = snap_r;
endmodule

/* core/axlr_dev.sv */
// register map end: axi4-lite slave with configuration and statistics pages
// How it works
// - idle rests; read request beats write request
// - write state drives address, data, strobes
// - write ends on response valid and ready
// - illegal write answers slave error, raises flag
// - read state drives address; ends on handshake
// - illegal read answers slave error, raises flag
// - acknowledge lasts one step, then idle
// - write response codes okay/exokay/slverr/decerr
// - read response uses the same codes
// - active-high reset sampled on the clock
// - data and addresses are 32 bits
// - master supplies four byte-lane strobes
// - read ready only when master can accept
// - two 512-byte pages at 0x000, 0x200
// - unmapped and gap addresses answer error
// - each register one aligned 32-bit word
// - reconfiguration-owned bits read as reserved
// - statistics page read-only but for the tick word; status clear-on-read, tick snapshot
`timescale 1ns/1ps
module axlr_dev
	import axlr_pkg::*;
#(
	parameter logic [31:0] VERSION = 32'h0000_0102, // arbitrary value
	parameter logic [31:0] RX_DRP_MASK = 32'h0000_0000,
	parameter int CNT_W = AXLR_CNT_W
)(
	input wire logic i_clk,
	input wire logic i_rst_n,
	axlr_if.dev bus,
	input wire logic [31:0] i_status_evt,
	input wire logic i_err_evt,
	output logic o_gt_reset_all,
	output logic [31:0] o_path_reset,
	output logic [31:0] o_tx_config,
	output logic [31:0] o_tx_diag_word,
	output logic [31:0] o_rx_config,
	output logic [31:0] o_loopback
);
	// ****************************************
	// declarations
	// ****************************************
	logic srst;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic wr_go;
	logic rd_go;
	logic wr_legal;
	logic rd_legal;
	logic [31:0] rd_word;
	logic gt_rst_r;
	logic [31:0] path_rst_r;
	logic [31:0] tx_cfg_r;
	logic [31:0] tx_diag_r;
	logic [31:0] rx_cfg_r;
	logic [31:0] loop_r;
	logic [31:0] status_r;
	logic snap;
	logic [CNT_W-1:0] cyc_cnt;
	logic [CNT_W-1:0] err_cnt;

	// writable words: configuration page except the version word, and the tick word
	function automatic logic addr_writable(input logic [31:0] a);
		return (a == OFF_XCVR_RST) || (a == OFF_PATH_RST) || (a == OFF_TX_CFG) ||
			(a == OFF_TX_DIAG) || (a == OFF_RX_CFG) || (a == OFF_LOOPBACK) || (a == OFF_TICK);
	endfunction

	// readable words: everything mapped
	function automatic logic addr_readable(input logic [31:0] a);
		return ((a >= CFG_PAGE_BASE) && (a < OFF_CFG_GAP) && (a[1:0] == 2'h0)) ||
			(a == OFF_STATUS) || (a == OFF_TICK) || (a == OFF_CYC_LSB) ||
			(a == OFF_CYC_MSB) || (a == OFF_ERR_LSB) || (a == OFF_ERR_MSB);
	endfunction

	assign srst = bus.bus_sync_reset;

	// ****************************************
	// write channel
	// ****************************************
	// one write when address and data both present
	assign wr_go = bus.awvalid && bus.wvalid && !awready_r && !bvalid_r;
	assign wr_legal = addr_writable(bus.awaddr);

	// address and data accept pulses
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
		end
		else if (srst)
		begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
		end
		else
		begin
			awready_r <= wr_go;
			wready_r <= wr_go;
		end
	end

	// response held until the master takes it
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end
		else if (srst)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_legal ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bvalid_r && bus.bready)
			bvalid_r <= 1'b0;
	end

	// ****************************************
	// configuration page
	// ****************************************
	// one word per register, byte lanes merged
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			path_rst_r <= CFG_RESET;
			tx_cfg_r <= CFG_RESET;
			tx_diag_r <= CFG_RESET;
			rx_cfg_r <= CFG_RESET;
			loop_r <= CFG_RESET;
		end
		else if (srst)
		begin
			path_rst_r <= CFG_RESET;
			tx_cfg_r <= CFG_RESET;
			tx_diag_r <= CFG_RESET;
			rx_cfg_r <= CFG_RESET;
			loop_r <= CFG_RESET;
		end
		else if (wr_go)
		begin
			case (bus.awaddr)
				OFF_PATH_RST: path_rst_r <= apply_strb(path_rst_r, bus.wdata, bus.wstrb);
				OFF_TX_CFG: tx_cfg_r <= apply_strb(tx_cfg_r, bus.wdata, bus.wstrb);
				OFF_TX_DIAG: tx_diag_r <= apply_strb(tx_diag_r, bus.wdata, bus.wstrb);
				// bits owned by reconfiguration are not stored
				OFF_RX_CFG: rx_cfg_r <= apply_strb(rx_cfg_r, bus.wdata, bus.wstrb) & ~RX_DRP_MASK;
				OFF_LOOPBACK: loop_r <= apply_strb(loop_r, bus.wdata, bus.wstrb);
				default: loop_r <= loop_r;
			endcase
		end
	end

	// transceiver reset: a written one fires a single pulse, reads back zero
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			gt_rst_r <= 1'b0;
		else if (srst)
			gt_rst_r <= 1'b0;
		else
			gt_rst_r <= wr_go && (bus.awaddr == OFF_XCVR_RST) && bus.wstrb[0] && bus.wdata[XCVR_RST_BIT];
	end

	// ****************************************
	// status and statistics page
	// ****************************************
	// snapshot on tick write or tick input
	assign snap = (wr_go && (bus.awaddr == OFF_TICK)) || bus.perf_snapshot_pulse;

	// latched-high status, cleared on read, new events win
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			status_r <= STATUS_RESET;
		else if (srst)
			status_r <= STATUS_RESET;
		else if (rd_go && (bus.araddr == OFF_STATUS))
			status_r <= i_status_evt;
		else
			status_r <= status_r | i_status_evt;
	end

	// cycle counter between snapshots
	axlr_stat_cnt #(.W(CNT_W)) u_cyc_cnt (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_srst(srst),
		.i_inc(1'b1),
		.i_snap(snap),
		.o_count(cyc_cnt)
	);

	// error event counter
	axlr_stat_cnt #(.W(CNT_W)) u_err_cnt (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_srst(srst),
		.i_inc(i_err_evt),
		.i_snap(snap),
		.o_count(err_cnt)
	);

	// ****************************************
	// read channel
	// ****************************************
	assign rd_go = bus.arvalid && !arready_r && !rvalid_r;
	// only the two pages' mapped words answer okay
	assign rd_legal = addr_readable(bus.araddr);

	// read data mux
	always_comb
	begin
		case (bus.araddr)
			OFF_VERSION: rd_word = VERSION;
			OFF_PATH_RST: rd_word = path_rst_r;
			OFF_TX_CFG: rd_word = tx_cfg_r;
			OFF_TX_DIAG: rd_word = tx_diag_r;
			OFF_RX_CFG: rd_word = rx_cfg_r;
			OFF_LOOPBACK: rd_word = loop_r;
			OFF_STATUS: rd_word = status_r;
			OFF_CYC_LSB: rd_word = cyc_cnt[31:0];
			OFF_CYC_MSB: rd_word = 32'(cyc_cnt >> CNT_MSB_SHIFT);
			OFF_ERR_LSB: rd_word = err_cnt[31:0];
			OFF_ERR_MSB: rd_word = 32'(err_cnt >> CNT_MSB_SHIFT);
			default: rd_word = 32'h0;
		endcase
	end

	// address accept pulse
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			arready_r <= 1'b0;
		else if (srst)
			arready_r <= 1'b0;
		else
			arready_r <= rd_go;
	end

	// data and response held until taken
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0;
		end
		else if (srst)
		begin
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0;
		end
		else if (rd_go)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= rd_legal ? RESP_OKAY : RESP_SLVERR;
			rdata_r <= rd_word;
		end
		else if (rvalid_r && bus.rready)
			rvalid_r <= 1'b0;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign bus.awready = awready_r;
	assign bus.wready = wready_r;
	assign bus.bvalid = bvalid_r;
	assign bus.bresp = bresp_r;
	assign bus.arready = arready_r;
	assign bus.rvalid = rvalid_r;
	assign bus.rresp = rresp_r;
	assign bus.rdata = rdata_r;
	assign o_gt_reset_all = gt_rst_r;
	assign o_path_reset = path_rst_r;
	assign o_tx_config = tx_cfg_r;
	assign o_tx_diag_word = tx_diag_r;
	assign o_rx_config = rx_cfg_r;
	assign o_loopback = loop_r;
endmodule

/* core/axlr_host.sv */
// controller end: apb-programmed single-access axi4-lite master
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module axlr_host
	import axlr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	axlr_if.host bus
);
	// ****************************************
	// declarations
	// ****************************************
	axlr_state_e state_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic apb_acc;
	logic apb_wr;
	logic [31:0] addr_r;
	logic [31:0] wdata_r;
	logic [3:0] strb_r;
	logic [31:0] rdata_r;
	logic rd_pend_r;
	logic wr_pend_r;
	logic done_r;
	logic werr_r;
	logic rerr_r;
	logic tick_r;
	logic [1:0] rst_cnt_r;
	logic bus_rst_r;
	logic [31:0] x_addr_r;
	logic [31:0] x_wdata_r;
	logic [3:0] x_strb_r;
	logic awvalid_r;
	logic wvalid_r;
	logic bready_r;
	logic arvalid_r;
	logic rready_r;
	logic take_rd;
	logic take_wr;
	logic b_done;
	logic r_done;
	logic busy;
	logic [31:0] rd_word;
	logic legal;

	assign apb_acc = i_psel && i_penable && !pready_r;
	// writes commit at the edge where the master sees pready high
	assign apb_wr = i_psel && i_penable && pready_r && i_pwrite;
	assign take_rd = (state_r == ST_IDLE) && rd_pend_r;
	assign take_wr = (state_r == ST_IDLE) && !rd_pend_r && wr_pend_r;
	assign b_done = (state_r == ST_WRITE) && bus.bvalid && bready_r;
	assign r_done = (state_r == ST_READ) && bus.rvalid && rready_r;
	assign busy = (state_r != ST_IDLE) || rd_pend_r || wr_pend_r;

	// ****************************************
	// apb slave
	// ****************************************
	// read mux and legality
	always_comb
	begin
		legal = 1'b1;
		case (i_paddr)
			H_OFF_CTRL: rd_word = 32'h0;
			H_OFF_ADDR: rd_word = addr_r;
			H_OFF_WDATA: rd_word = wdata_r;
			H_OFF_STRB: rd_word = {28'h0, strb_r};
			H_OFF_RDATA: rd_word = rdata_r;
			H_OFF_STATUS: rd_word = {28'h0, rerr_r, werr_r, done_r, busy};
			H_OFF_TICK: rd_word = 32'h0;
			default:
			begin
				rd_word = 32'h0;
				legal = 1'b0;
			end
		endcase
	end

	// answer one cycle into the access phase
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end
		else
		begin
			pready_r <= apb_acc;
			pslverr_r <= apb_acc && (!legal || (i_pwrite && (i_paddr == H_OFF_RDATA)));
			prdata_r <= (apb_acc && !i_pwrite) ? rd_word : 32'h0;
		end
	end

	// order words
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			addr_r <= 32'h0;
			wdata_r <= 32'h0;
			strb_r <= STRB_RESET;
		end
		else if (apb_wr)
		begin
			if (i_paddr == H_OFF_ADDR)
				addr_r <= i_pwdata;
			if (i_paddr == H_OFF_WDATA)
				wdata_r <= i_pwdata;
			if (i_paddr == H_OFF_STRB)
				strb_r <= i_pwdata[3:0];
		end
	end

	// pending requests; a new order wins over its take
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rd_pend_r <= 1'b0;
			wr_pend_r <= 1'b0;
		end
		else
		begin
			rd_pend_r <= (rd_pend_r && !take_rd) || (apb_wr && (i_paddr == H_OFF_CTRL) && i_pwdata[CTRL_RD_BIT]);
			wr_pend_r <= (wr_pend_r && !take_wr) || (apb_wr && (i_paddr == H_OFF_CTRL) && i_pwdata[CTRL_WR_BIT]);
		end
	end

	// sticky status, write one to clear, hardware set wins
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			done_r <= 1'b0;
			werr_r <= 1'b0;
			rerr_r <= 1'b0;
		end
		else
		begin
			done_r <= (done_r && !(apb_wr && (i_paddr == H_OFF_STATUS) && i_pwdata[ST_DONE_BIT]))
				|| (state_r == ST_ACK);
			werr_r <= (werr_r && !(apb_wr && (i_paddr == H_OFF_STATUS) && i_pwdata[ST_WERR_BIT]))
				|| (b_done && is_err(bus.bresp));
			rerr_r <= (rerr_r && !(apb_wr && (i_paddr == H_OFF_STATUS) && i_pwdata[ST_RERR_BIT]))
				|| (r_done && is_err(bus.rresp));
		end
	end

	// snapshot pulse and bus reset hold
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tick_r <= 1'b0;
			rst_cnt_r <= BUS_RST_CYCLES;
			bus_rst_r <= 1'b1;
		end
		else
		begin
			tick_r <= apb_wr && (i_paddr == H_OFF_TICK);
			bus_rst_r <= (rst_cnt_r > 2'h1); // registered copy of the hold
			if (rst_cnt_r != 2'h0)
				rst_cnt_r <= rst_cnt_r - 2'h1;
		end
	end

	// ****************************************
	// access state machine
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			state_r <= ST_IDLE;
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					if (take_rd)
						state_r <= ST_READ;
					else if (take_wr)
						state_r <= ST_WRITE;
				end
				ST_WRITE: if (b_done) state_r <= ST_ACK;
				ST_READ: if (r_done) state_r <= ST_ACK;
				ST_ACK: state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// payload frozen for the whole access
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			x_addr_r <= 32'h0;
			x_wdata_r <= 32'h0;
			x_strb_r <= 4'h0;
		end
		else if (take_rd || take_wr)
		begin
			x_addr_r <= addr_r;
			x_wdata_r <= wdata_r;
			x_strb_r <= strb_r;
		end
	end

	// write channels valid until each ready
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			awvalid_r <= 1'b0;
			wvalid_r <= 1'b0;
			bready_r <= 1'b0;
		end
		else
		begin
			awvalid_r <= take_wr || (awvalid_r && !bus.awready);
			wvalid_r <= take_wr || (wvalid_r && !bus.wready);
			bready_r <= take_wr || (bready_r && !b_done);
		end
	end

	// read address valid, ready while waiting for data
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			arvalid_r <= 1'b0;
			rready_r <= 1'b0;
			rdata_r <= 32'h0;
		end
		else
		begin
			arvalid_r <= take_rd || (arvalid_r && !bus.arready);
			rready_r <= take_rd || (rready_r && !r_done);
			if (r_done)
				rdata_r <= bus.rdata;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign o_pready = pready_r;
	assign o_pslverr = pslverr_r;
	assign o_prdata = prdata_r;
	assign bus.awaddr = x_addr_r;
	assign bus.araddr = x_addr_r;
	assign bus.wdata = x_wdata_r;
	assign bus.wstrb = x_strb_r;
	assign bus.awvalid = awvalid_r;
	assign bus.wvalid = wvalid_r;
	assign bus.bready = bready_r;
	assign bus.arvalid = arvalid_r;
	assign bus.rready = rready_r;
	assign bus.bus_sync_reset = bus_rst_r;
	assign bus.perf_snapshot_pulse = tick_r;
endmodule

/* sim/axlr_asserts.sv */
// concurrent checks on the axi4-lite link between the two ends
`timescale 1ns/1ps
module axlr_asserts
	import axlr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic bus_sync_reset,
	input wire logic [AXLR_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic [AXLR_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [AXLR_DATA_W-1:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid
);
	// ****************************************
	// link properties
	// ****************************************
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n || bus_sync_reset);
	logic wtake;
	logic rtake;
	// request taken by the register map
	assign wtake = awvalid && wvalid && !awready && !bvalid;
	assign rtake = arvalid && !arready && !rvalid;
	AST_WR_TIME: assert property (wtake |=> awready && wready && bvalid)
		else $error("write answer late");
	AST_RD_TIME: assert property (rtake |=> arready && rvalid)
		else $error("read answer late");
	AST_HOLD: assert property (awvalid && !awready |=> awvalid && $stable(awaddr))
		else $error("write request dropped early");
	AST_WR_END: assert property (wtake |=> ##1 !bvalid && !awvalid)
		else $error("write not closed in one step");
	AST_WR_GAP: assert property (wtake && awaddr >= 32'h1c && awaddr < 32'h200 |=> bresp == 2'b10)
		else $error("reserved write not refused");
	AST_RD_GAP: assert property (rtake && araddr >= 32'h1c && araddr < 32'h200 |=> rresp == 2'b10 && rdata == 0)
		else $error("reserved read not refused");
	AST_WR_OK: assert property (wtake && awaddr inside {32'h8, 32'hc, 32'h14} |=> bresp == 2'b00)
		else $error("mapped write refused");
	AST_STAT_RO: assert property (wtake && awaddr == 32'h200 |=> bresp == 2'b10)
		else $error("status page write accepted");
	AST_ONE_ACC: assert property (!(awvalid && arvalid))
		else $error("read and write at once");
	COV_WR: cover property (wtake ##1 bresp == 2'b00);
	COV_WERR: cover property (wtake ##1 bresp == 2'b10);
	COV_RD: cover property (rtake ##1 rresp == 2'b00);
endmodule

/* sim/axlr_tb.sv */
// self-checking bench for the two ends joined over axi4-lite
`timescale 1ns/1ps
module axlr_tb
	import axlr_pkg::*;
;
	localparam logic [31:0] VER = 32'h0000_0a5c; // arbitrary value
	localparam logic [31:0] DRP = 32'h0000_ff00; // reconfiguration-owned rx bits
	logic i_clk = 0, i_rst_n = 0, psel = 0, pen = 0, pwr = 0, eev = 0, prdy, perr, gtr, e;
	logic [31:0] paddr = 0, pwd = 0, stv = 0, prd, path, rd, st, txc, txd, rxc, lpb;
	logic [31:0] bad [4] = '{32'h0, 32'h1c, 32'h1fc, 32'h200};
	int num_errors = 0, checks_done = 0, cyc = 0, gtn = 0;
	axlr_if bus ();
	axlr_host u_axlr_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .bus(bus));
	axlr_dev #(.VERSION(VER), .RX_DRP_MASK(DRP)) u_axlr_dev (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(bus),
		.i_status_evt(stv), .i_err_evt(eev), .o_gt_reset_all(gtr), .o_path_reset(path), .o_tx_config(txc),
		.o_tx_diag_word(txd), .o_rx_config(rxc), .o_loopback(lpb));
	axlr_asserts u_axlr_asserts (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus_sync_reset(bus.bus_sync_reset),
		.awaddr(bus.awaddr), .awvalid(bus.awvalid), .awready(bus.awready), .wvalid(bus.wvalid),
		.wready(bus.wready), .bresp(bus.bresp), .bvalid(bus.bvalid), .araddr(bus.araddr),
		.arvalid(bus.arvalid), .arready(bus.arready), .rdata(bus.rdata), .rresp(bus.rresp), .rvalid(bus.rvalid));
	// ****************************************
	// clock, watchdog, helpers
	// ****************************************
	initial forever #50 i_clk = ~i_clk;
	// cycle ceiling and reset pulse count
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (gtr === 1'b1)
			gtn <= gtn + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [31:0] a, d);
		@(posedge i_clk);
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge i_clk);
		pen <= 1;
		do @(posedge i_clk); while (prdy !== 1'b1);
		rd = prd;
		e = perr;
		psel <= 0;
		pen <= 0;
	endtask
	// one link access through the controller
	task automatic acc(input logic w, input logic [31:0] a, d, input logic [3:0] s);
		apb(1, H_OFF_ADDR, a);
		apb(1, H_OFF_WDATA, d);
		apb(1, H_OFF_STRB, {28'h0, s});
		apb(1, H_OFF_STATUS, 32'hf);
		apb(1, H_OFF_CTRL, w ? 32'h1 : 32'h2);
		do apb(0, H_OFF_STATUS, 0); while (rd[ST_DONE_BIT] !== 1'b1);
		st = rd & 32'hc;
		apb(0, H_OFF_RDATA, 0);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1;
		repeat (3) @(posedge i_clk);
		acc(0, OFF_VERSION, 0, 4'hf);
		chk(rd, VER);
		acc(1, OFF_PATH_RST, 32'h1234_5678, 4'hf);
		acc(1, OFF_PATH_RST, 32'haabb_ccdd, 4'h1);
		chk(path, 32'h1234_56dd);
		for (int i = 3; i < 7; i++)
		begin
			acc(1, 32'(i * 4), 32'h1111_1111 * i, 4'hf);
			acc(0, 32'(i * 4), 0, 4'hf);
			chk(rd, (32'h1111_1111 * i) & ((i == 5) ? ~DRP : 32'hffff_ffff));
			chk(st, 0);
		end
		chk(txc, 32'h3333_3333);
		chk(txd, 32'h4444_4444);
		chk(rxc, 32'h5555_0055);
		chk(lpb, 32'h6666_6666);
		foreach (bad[k])
		begin
			acc(1, bad[k], 32'hffff_ffff, 4'hf);
			chk(st, 32'h4);
		end
		for (int k = 1; k < 3; k++)
		begin
			acc(0, bad[k], 0, 4'hf);
			chk(st | rd, 32'h8);
		end
		acc(1, OFF_XCVR_RST, 1, 4'hf);
		acc(0, OFF_XCVR_RST, 0, 4'hf);
		chk(rd, 0);
		chk(32'(gtn), 1);
		apb(1, H_OFF_TICK, 0);
		repeat (2) @(posedge i_clk);
		eev <= 1;
		repeat (5) @(posedge i_clk);
		eev <= 0;
		stv <= 32'h5;
		@(posedge i_clk);
		stv <= 0;
		acc(1, OFF_TICK, 0, 4'hf);
		acc(0, OFF_ERR_LSB, 0, 4'hf);
		chk(rd, 5);
		acc(0, OFF_ERR_MSB, 0, 4'hf);
		chk(rd, 0);
		acc(0, OFF_CYC_LSB, 0, 4'hf);
		chk({31'h0, rd > 32'h8}, 1);
		acc(0, OFF_CYC_MSB, 0, 4'hf);
		chk(rd, 0);
		acc(0, OFF_STATUS, 0, 4'hf);
		chk(rd, 5);
		acc(0, OFF_STATUS, 0, 4'hf);
		chk(rd, 0);
		apb(1, 32'h40, 0);
		chk({31'h0, e}, 1);
		test_done();
	end
endmodule
